// file: test/io_mmu_monitor.sv
// io_mmu_monitor.sv: port checker for the translation and prefetch unit.
// assumes it is bound to io_mmu_translation_prefetch; one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none
`include "iommu_params.svh"
module io_mmu_monitor (
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire logic              translate_enable,
  input wire logic              protection_vector_mode,
  input wire logic              prefetch_disable,
  input wire logic              flush_request,
  input wire logic              flush_clear,
  input wire logic              flush_flag,
  input wire logic              req_valid,
  input wire logic [`ADDR_W-1:0] req_addr,
  input wire logic              req_burst_read,
  input wire logic              req_cacheable,
  input wire logic              req_vector_allow,
  input wire logic              req_ready,
  input wire logic              out_valid,
  input wire logic [`ADDR_W-1:0] out_addr,
  input wire logic              out_denied,
  input wire logic              walk_req,
  input wire logic              walk_done,
  input wire logic              pf_req
);
  logic acc;
  assign acc = req_valid && req_ready;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_vector_pass: assert property (
    acc && protection_vector_mode && req_vector_allow |=> out_valid && out_addr == $past(req_addr))
    else $error("vector address changed");
  a_vector_deny: assert property (
    acc && protection_vector_mode |=> out_denied == !$past(req_vector_allow))
    else $error("vector deny wrong");
  a_pf_off: assert property (prefetch_disable |-> !pf_req)
    else $error("prefetch while disabled");
  a_pf_cause: assert property (
    pf_req |-> req_burst_read && (req_cacheable || translate_enable))
    else $error("prefetch without cause");
  a_pf_start: assert property (
    acc && req_burst_read && req_cacheable && !prefetch_disable && !protection_vector_mode
    |-> ##[1:20] pf_req)
    else $error("prefetch missing");
  a_flush_set: assert property (
    flush_request || (flush_flag && !flush_clear) |=> flush_flag)
    else $error("flush flag lost");
  a_flush_clr: assert property (flush_clear && !flush_request |=> !flush_flag)
    else $error("flush flag stuck");
  a_flag_walks: assert property (
    acc && flush_flag && translate_enable && !protection_vector_mode |-> ##2 walk_req)
    else $error("hit while flushing");
  a_walk_answer: assert property (walk_req && walk_done |=> out_valid)
    else $error("walk not answered");
endmodule : io_mmu_monitor
bind io_mmu_translation_prefetch io_mmu_monitor mon_u (.ref_clk, .sys_rst, .translate_enable,
  .protection_vector_mode, .prefetch_disable, .flush_request, .flush_clear, .flush_flag,
  .req_valid, .req_addr, .req_burst_read, .req_cacheable, .req_vector_allow, .req_ready,
  .out_valid, .out_addr, .out_denied, .walk_req, .walk_done, .pf_req);
`default_nettype wire

// file: test/sys_side_model.sv
// sys_side_model.sv: page walker and the two system buses behind the unit.
// assumes walk_req and pf_req are levels on ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "iommu_params.svh"
module sys_side_model (
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic               slow,
  input  wire logic               walk_req,
  input  wire logic [`TAG_W-1:0]  walk_vpn,
  output logic                    walk_done,
  output logic [`TAG_W-1:0]       walk_ppn,
  input  wire logic               pf_req,
  input  wire logic [`ADDR_W-1:0] pf_addr,
  output logic                    cpu_bus_valid,
  output logic [`DATA_W-1:0]      cpu_bus_rdata,
  output logic                    mem_bus_valid,
  output logic [`DATA_W-1:0]      mem_bus_rdata
);
  logic [1:0] cnt_q;
  logic       gate_q;
  always_ff @(posedge ref_clk) begin
    cnt_q <= (sys_rst || !walk_req || walk_done) ? 2'h0 : cnt_q + 2'h1;
    gate_q <= !sys_rst && !gate_q;
  end
  // fixed page map; ppn outside the done pulse is junk on purpose
  assign walk_done = walk_req && (cnt_q == (slow ? 2'h3 : 2'h1));
  assign walk_ppn = walk_done ? walk_vpn ^ 20'h5a5a5 : ~walk_vpn;
  // both buses answer at once with different data, so a wrong mux shows
  assign cpu_bus_valid = pf_req && (gate_q || !slow);
  assign mem_bus_valid = cpu_bus_valid;
  assign cpu_bus_rdata = cpu_bus_valid ? pf_addr ^ 32'hc0c0_0000 : ~pf_addr;
  assign mem_bus_rdata = mem_bus_valid ? pf_addr ^ 32'h0d0d_0000 : pf_addr;
endmodule : sys_side_model
`default_nettype wire

// file: test/tb_top.sv
// tb_top.sv: self-checking bench for the translation and prefetch unit.
// assumes the unit and sys_side_model share one 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        ref_clk, sys_rst, translate_enable, protection_vector_mode, tlb_enable;
  logic        prefetch_disable, bus_select, flush_request, flush_clear, flush_flag;
  logic        flush_busy, req_valid, req_burst_read, req_cacheable, req_vector_allow;
  logic        req_ready, out_valid, out_denied, walk_req, walk_done, pf_req, pf_valid;
  logic        cpu_bus_valid, mem_bus_valid, slow, walked, dn, pfs, diag_enable;
  logic [3:0]  diag_index;
  logic [2:0]  page_size, pf_rd_idx;
  logic [19:0] walk_vpn, walk_ppn;
  logic [31:0] req_addr, out_addr, pf_addr, cpu_bus_rdata, mem_bus_rdata, pf_rd_data, got, a;
  logic [3:0]  tbl [4] = '{4'h0, 4'h9, 4'h6, 4'ha};
  int          mismatches, n_compared;
  io_mmu_translation_prefetch dut_u (.ref_clk, .sys_rst, .translate_enable, .protection_vector_mode,
    .tlb_enable, .prefetch_disable, .bus_select, .diag_enable, .diag_index,
    .flush_request, .flush_clear, .page_size, .translation_range_field(3'h1),
    .flush_flag, .flush_busy, .req_valid, .req_addr, .req_burst_read, .req_cacheable,
    .req_vector_allow, .req_ready, .out_valid, .out_addr, .out_denied, .walk_req, .walk_vpn,
    .walk_done, .walk_ppn, .pf_req, .pf_addr, .cpu_bus_valid, .cpu_bus_rdata, .mem_bus_valid,
    .mem_bus_rdata, .pf_rd_idx, .pf_rd_data, .pf_valid);
  sys_side_model model_u (.ref_clk, .sys_rst, .slow, .walk_req, .walk_vpn, .walk_done,
    .walk_ppn, .pf_req, .pf_addr, .cpu_bus_valid, .cpu_bus_rdata, .mem_bus_valid, .mem_bus_rdata);
  always #50 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  function automatic logic [31:0] xl(input logic [31:0] v, input logic [2:0] k);
    logic [31:0] m;
    m = (32'h1 << (12 + k)) - 32'h1;
    return ({v[31:12] ^ 20'h5a5a5, 12'h000} & ~m) | (v & m);
  endfunction : xl
  // burst stays up until the prefetch ends, as the unit expects
  task automatic do_req(input logic [31:0] v, input logic b, input logic c, input logic ok);
    int n;
    n = 0;
    walked = 0;
    {req_addr, req_burst_read, req_cacheable, req_vector_allow, req_valid} = {v, b, c, ok, 1'b1};
    while (req_ready !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    tick(1);
    req_valid = 0;
    while (out_valid !== 1'b1 && n < 99) begin
      walked |= walk_req;
      tick(1);
      n++;
    end
    {got, dn, pfs} = {out_addr, out_denied, pf_req === 1'b1};
    while (pf_req === 1'b1 && n < 199) begin
      tick(1);
      n++;
    end
    req_burst_read = 0;
    check(n < 99, 1);
    // an edge passes so the next call never redrives the request in the same step
    tick(1);
  endtask : do_req
  task automatic t_vector();
    protection_vector_mode = 1;
    do_req(32'h1234_5678, 0, 0, 1);
    check(got, 32'h1234_5678);
    check(walked, 0);
    do_req(32'h2000_0004, 1, 1, 0);
    check(dn, 1);
    check(pfs, 0);
    protection_vector_mode = 0;
  endtask : t_vector
  task automatic t_translate();
    translate_enable = 1;
    for (int i = 0; i < 6; i++) begin
      // large pages run with the buffer off only in the last round; the round before it uses 4 KiB pages
      {tlb_enable, slow, page_size} = {i < 4, i[0], 3'(i * 2 % 8)};
      a = 32'h4007_f120 + i * 32'h0010_0000;
      for (int j = 0; j < 2; j++) begin
        do_req(a + j * 4, 0, 0, 1);
        check(got, xl(a + j * 4, page_size));
        check(walked, j == 0 || i > 3);
      end
    end
  endtask : t_translate
  task automatic t_flush();
    {tlb_enable, page_size, slow} = {1'b1, 3'h0, 1'b0};
    for (int k = 0; k < 2; k++) begin
      do_req(32'h5000_0040, 0, 0, 1);
      do_req(32'h5000_0040, 0, 0, 1);
      check(walked, 0);
      flush_request = 1;
      tick(1);
      flush_request = 0;
      check({flush_busy, flush_flag}, 2'h3);
      if (k == 0) begin
        // dma stays quiet until the flag is cleared
        tick(20);
        check(flush_flag, 1);
      end else begin
        do_req(32'h5000_0040, 0, 0, 1);
        do_req(32'h5000_0040, 0, 0, 1);
        check(walked, 1);
      end
      flush_clear = 1;
      tick(1);
      flush_clear = 0;
      tick(1);
      check(flush_flag, 0);
      // the flush emptied the buffer and nothing is cached while the flag stands, so both rounds walk again
      do_req(32'h5000_0040, 0, 0, 1);
      check(walked, 1);
    end
  endtask : t_flush
  // a diagnostic index overrides the address index for lookups and fills alike
  task automatic t_diag();
    {diag_index, tlb_enable, translate_enable, page_size} = {4'h0, 1'b1, 1'b1, 3'h0};
    for (int d = 0; d < 3; d++) begin
      diag_enable = d < 2;
      do_req(32'h7000_3000, 0, 0, 1);
      check(got, xl(32'h7000_3000, page_size));
      check(walked, d != 1);
    end
    diag_enable = 0;
  endtask : t_diag
  task automatic t_prefetch();
    translate_enable = 0;
    for (int i = 0; i < 4; i++) begin
      {bus_select, slow} = {i[0], i[1]};
      do_req(32'h0000_8000 + i * 32'h100, 1, 1, 1);
      check(pf_valid, 1);
      for (int w = 0; w < 8; w++) begin
        pf_rd_idx = 3'(w);
        tick(1);
        check(pf_rd_data, (got + w * 4) ^ (bus_select ? 32'h0d0d_0000 : 32'hc0c0_0000));
      end
    end
    // last case disables prefetch under protection, as software may
    for (int i = 0; i < 4; i++) begin
      {translate_enable, prefetch_disable} = {tbl[i][3], tbl[i][1]};
      do_req(32'h6000_0100, 1, tbl[i][2], 1);
      check(pfs, tbl[i][0]);
    end
  endtask : t_prefetch
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    {ref_clk, sys_rst, translate_enable, protection_vector_mode, tlb_enable} = 5'h08;
    {prefetch_disable, bus_select, flush_request, flush_clear, req_valid} = 5'h00;
    {diag_enable, diag_index} = 5'h00;
    {req_burst_read, req_cacheable, req_vector_allow, slow, page_size, pf_rd_idx} = 0;
    {req_addr, mismatches, n_compared} = 0;
    tick(5);
    sys_rst = 0;
    t_vector();
    t_translate();
    t_flush();
    t_diag();
    t_prefetch();
    print_verdict();
  end
  initial begin
    #2_000_000;
    mismatches++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// file: verilog/io_mmu_translation_prefetch.sv
// io_mmu_translation_prefetch.sv: dma address protection, translation and read prefetch.
// assumes one ref_clk domain; the page walker and both system buses answer on that clock.
//
// Summary of operation
// [R1] large pages pass in-page address bits from bit 12 upward untranslated.
// [R2] on a buffer hit, the bits of 31:12 above the in-page bits come from the cached page entry.
// [R3] protection-vector mode checks rights only; address out equals address in.
// [R4] cacheable burst reads from the dma side fill the prefetch buffer.
// [R5] with translation protection on, every access counts as cacheable.
// [R6] prefetch data come through a mux chosen by the bus select.
// [R7] prefetch_disable high stops all prefetching; low lets it run.
// [R8] software normally keeps prefetch on; may disable it under protection.
// [R9] buffer address comes from diagnostic bits or flush_flag, else from the dma address.
// [R10] software halts dma before flush, resumes after flush_flag clears.
// [R11] a flush invalidates all cached entries; next access walks page tables.
// [R12] software on 4 KiB pages may program a small translation_range_field.
// [R13] large pages under translation are safe only with the buffer disabled.
// [R14] flush_flag stays set after a request until software clears it.
`timescale 1ns/1ns
`default_nettype none
`include "iommu_params.svh"
module io_mmu_translation_prefetch (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  // control and status
  input  wire logic                   translate_enable,
  input  wire logic                   protection_vector_mode,
  input  wire logic                   tlb_enable,
  input  wire logic                   prefetch_disable,
  input  wire logic                   bus_select,
  input  wire logic                   diag_enable,
  input  wire logic [`TLB_IDX_W-1:0]  diag_index,
  input  wire logic                   flush_request,
  input  wire logic                   flush_clear,
  input  wire logic [`PSIZE_W-1:0]    page_size,
  input  wire logic [`PSIZE_W-1:0]    translation_range_field,
  output logic                        flush_flag,
  output logic                        flush_busy,
  // dma side request
  input  wire logic                   req_valid,
  input  wire logic [`ADDR_W-1:0]     req_addr,
  input  wire logic                   req_burst_read,
  input  wire logic                   req_cacheable,
  input  wire logic                   req_vector_allow,
  output logic                        req_ready,
  output logic                        out_valid,
  output logic [`ADDR_W-1:0]          out_addr,
  output logic                        out_denied,
  // page table walker
  output logic                        walk_req,
  output logic [`TAG_W-1:0]           walk_vpn,
  input  wire logic                   walk_done,
  input  wire logic [`TAG_W-1:0]      walk_ppn,
  // prefetch fetch from the two system buses
  output logic                        pf_req,
  output logic [`ADDR_W-1:0]          pf_addr,
  input  wire logic                   cpu_bus_valid,
  input  wire logic [`DATA_W-1:0]     cpu_bus_rdata,
  input  wire logic                   mem_bus_valid,
  input  wire logic [`DATA_W-1:0]     mem_bus_rdata,
  input  wire logic [`PF_IDX_W-1:0]   pf_rd_idx,
  output logic [`DATA_W-1:0]          pf_rd_data,
  output logic                        pf_valid
);
  tlb_if tlb ();
  tlb_mem tlb_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .port_if(tlb));

  iommu_pkg::state_type state_q, state_d;
  logic [`ADDR_W-1:0]    addr_q, addr_d;
  logic [`ADDR_W-1:0]    oaddr_q, oaddr_d;
  logic                  ovalid_q, ovalid_d;
  logic                  denied_q, denied_d;
  logic                  flag_q, flag_d;
  logic                  inv_q, inv_d;
  logic                  look_q, look_d;
  logic [`PF_IDX_W-1:0]  pf_cnt_q, pf_cnt_d;
  logic                  pf_full_q, pf_full_d;
  logic [`DATA_W-1:0]    pf_buf_q [`PF_DEPTH];
  logic [`DATA_W-1:0]    rd_q;
  logic                  bus_valid;
  logic [`DATA_W-1:0]    bus_rdata;
  logic [`ADDR_W-1:0]    tlb_addr;
  iommu_pkg::mode_type   mode;

  // mask of in-page bits from bit 12 upward for the selected page size
  function automatic logic [`TAG_W-1:0] inpage_mask(input logic [`PSIZE_W-1:0] sz);
    inpage_mask = ~({`TAG_W{1'b1}} << sz);
  endfunction : inpage_mask

  // merge a page entry with untranslated in-page bits
  function automatic logic [`ADDR_W-1:0] merge_addr(input logic [`TAG_W-1:0] ppn,
                                                    input logic [`ADDR_W-1:0] a,
                                                    input logic [`PSIZE_W-1:0] sz);
    logic [`TAG_W-1:0] m;
    m = inpage_mask(sz);
    merge_addr = {(ppn & ~m) | (a[`ADDR_W-1:`PAGE_LSB] & m), a[`PAGE_LSB-1:0]}; // see [R1] see [R2]
  endfunction : merge_addr

  always_comb begin
    if (protection_vector_mode) begin
      mode = iommu_pkg::mode_vector_type_v;
    end else if (translate_enable) begin
      mode = iommu_pkg::mode_translate_type_v;
    end else begin
      mode = iommu_pkg::mode_bypass_type_v;
    end
  end

  // the prefetch buffer listens to the selected bus, not always the cpu bus
  assign bus_valid = bus_select ? mem_bus_valid : cpu_bus_valid; // see [R6]
  assign bus_rdata = bus_select ? mem_bus_rdata : cpu_bus_rdata; // see [R6]

  // capture edge looks up the incoming address, else the registered hit would belong to the last one
  assign tlb_addr = (state_q == iommu_pkg::st_idle && !look_q) ? req_addr : addr_q;

  // buffer address: diagnostic index, else a fixed slot while flushing, else dma address
  always_comb begin
    tlb.inv_all    = inv_q;
    tlb.lookup_tag = tlb_addr[`ADDR_W-1:`PAGE_LSB];
    tlb.wr_tag     = addr_q[`ADDR_W-1:`PAGE_LSB];
    tlb.wr_ppn     = walk_ppn;
    tlb.wr_en      = state_q == iommu_pkg::st_walk && walk_done && tlb_enable && !flag_q;
    if (diag_enable) begin
      tlb.idx = diag_index; // see [R9]
    end else if (flag_q) begin
      tlb.idx = `TLB_IDX_RST; // see [R9]
    end else begin
      tlb.idx = tlb_addr[`PAGE_LSB +: `TLB_IDX_W];
    end
  end

  always_comb begin
    state_d   = state_q;
    addr_d    = addr_q;
    oaddr_d   = oaddr_q;
    ovalid_d  = 1'b0;
    denied_d  = 1'b0;
    look_d    = 1'b0;
    pf_cnt_d  = pf_cnt_q;
    pf_full_d = pf_full_q;
    inv_d     = flush_request;
    // set wins over clear; flag is left to software, not to flush completion
    flag_d    = (flag_q && !flush_clear) || flush_request; // see [R14]
    unique case (state_q)
      iommu_pkg::st_idle: begin
        if (look_q) begin
          // buffer answered for addr_q one cycle after capture
          if (tlb.hit && tlb_enable && !flag_q) begin
            oaddr_d  = merge_addr(tlb.rd_ppn, addr_q, page_size);
            ovalid_d = 1'b1;
            if (req_burst_read && !prefetch_disable) begin
              state_d  = iommu_pkg::st_prefetch;
              pf_cnt_d = `PF_IDX_RST;
              pf_full_d = 1'b0;
            end
          end else begin
            state_d = iommu_pkg::st_walk; // see [R11]
          end
        end else if (req_valid) begin
          addr_d = req_addr;
          unique case (mode)
            iommu_pkg::mode_translate_type_v: begin
              look_d = 1'b1;
            end
            iommu_pkg::mode_vector_type_v: begin
              oaddr_d  = req_addr; // see [R3]
              ovalid_d = 1'b1;
              denied_d = !req_vector_allow; // see [R3]
            end
            iommu_pkg::mode_bypass_type_v: begin
              oaddr_d  = req_addr;
              ovalid_d = 1'b1;
            end
          endcase
          if (mode != iommu_pkg::mode_translate_type_v && req_burst_read && req_cacheable
              && !(mode == iommu_pkg::mode_vector_type_v && !req_vector_allow)
              && !prefetch_disable) begin // see [R4] see [R7]
            state_d   = iommu_pkg::st_prefetch;
            pf_cnt_d  = `PF_IDX_RST;
            pf_full_d = 1'b0;
          end
        end
      end
      iommu_pkg::st_walk: begin
        if (walk_done) begin
          oaddr_d  = merge_addr(walk_ptn_fix(walk_ppn), addr_q, page_size);
          ovalid_d = 1'b1;
          // translation makes every access cacheable
          if (req_burst_read && !prefetch_disable) begin // see [R5] see [R7]
            state_d   = iommu_pkg::st_prefetch;
            pf_cnt_d  = `PF_IDX_RST;
            pf_full_d = 1'b0;
          end else begin
            state_d = iommu_pkg::st_idle;
          end
        end
      end
      iommu_pkg::st_prefetch: begin
        if (prefetch_disable) begin
          state_d = iommu_pkg::st_idle; // see [R7]
        end else if (bus_valid) begin
          pf_cnt_d = pf_cnt_q + `PF_STEP;
          if (pf_cnt_q == `PF_LAST) begin
            pf_full_d = 1'b1;
            state_d   = iommu_pkg::st_idle;
          end
        end
      end
    endcase
  end

  // identity hook kept so walk results and cached entries share one merge path
  function automatic logic [`TAG_W-1:0] walk_ptn_fix(input logic [`TAG_W-1:0] p);
    walk_ptn_fix = p;
  endfunction : walk_ptn_fix

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q   <= iommu_pkg::st_idle;
      addr_q    <= `ADDR_RST;
      oaddr_q   <= `ADDR_RST;
      ovalid_q  <= 1'b0;
      denied_q  <= 1'b0;
      flag_q    <= 1'b0;
      inv_q     <= 1'b0;
      look_q    <= 1'b0;
      pf_cnt_q  <= `PF_IDX_RST;
      pf_full_q <= 1'b0;
      rd_q      <= `DATA_RST;
    end else begin
      state_q   <= state_d;
      addr_q    <= addr_d;
      oaddr_q   <= oaddr_d;
      ovalid_q  <= ovalid_d;
      denied_q  <= denied_d;
      flag_q    <= flag_d;
      inv_q     <= inv_d;
      look_q    <= look_d;
      pf_cnt_q  <= pf_cnt_d;
      pf_full_q <= pf_full_d;
      rd_q      <= pf_buf_q[pf_rd_idx];
    end
  end

  // buffer words need no reset; pf_valid tells when they hold data
  always_ff @(posedge ref_clk) begin
    if (state_q == iommu_pkg::st_prefetch && bus_valid) begin
      pf_buf_q[pf_cnt_q] <= bus_rdata; // see [R4] see [R6]
    end
  end

  assign req_ready  = state_q == iommu_pkg::st_idle && !look_q;
  assign out_valid  = ovalid_q;
  assign out_addr   = oaddr_q;
  assign out_denied = denied_q;
  assign flush_flag = flag_q;
  assign flush_busy = inv_q;
  assign walk_req   = state_q == iommu_pkg::st_walk;
  assign walk_vpn   = addr_q[`ADDR_W-1:`PAGE_LSB];
  assign pf_req     = state_q == iommu_pkg::st_prefetch;
  assign pf_addr    = oaddr_q + {{(`ADDR_W-`PF_IDX_W-2){1'b0}}, pf_cnt_q, 2'h0};
  assign pf_rd_data = rd_q;
  assign pf_valid   = pf_full_q;
endmodule : io_mmu_translation_prefetch
`default_nettype wire

// file: verilog/iommu_params.svh
// iommu_params.svh: constants of the i/o memory management unit.
// assumes nothing beyond the include guard; included by every design file.
`ifndef IOMMU_PARAMS_SVH
`define IOMMU_PARAMS_SVH
`define ADDR_W          32
`define DATA_W          32
`define PAGE_LSB        12
`define TAG_W           20
`define PSIZE_W         3
`define TLB_DEPTH       16
`define TLB_IDX_W       4
`define PF_DEPTH        8
`define PF_IDX_W        3
`define PSIZE_4K        3'h0
`define PF_LAST         3'h7
`define PF_STEP         3'h1
`define TLB_IDX_RST     4'h0
`define PF_IDX_RST      3'h0
`define ADDR_RST        32'h0000_0000
`define DATA_RST        32'h0000_0000
`define TAG_RST         20'h0_0000
`endif

// file: verilog/iommu_pkg.sv
// iommu_pkg.sv: mode and state types of the translation unit; the look-aside buffer uses none.
// assumes iommu_params.svh is on the include path.
`include "iommu_params.svh"
package iommu_pkg;
  typedef enum logic [1:0] {
    mode_bypass_type_v,
    mode_vector_type_v,
    mode_translate_type_v
  } mode_type;
  typedef enum {
    st_idle,
    st_walk,
    st_prefetch
  } state_type;
endpackage : iommu_pkg

// file: verilog/tlb_if.sv
// tlb_if.sv: port bundle between the translation unit and its look-aside memory.
// assumes the user connects both ends to the same ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "iommu_params.svh"
interface tlb_if;
  logic                       wr_en;
  logic                       inv_all;
  logic [`TLB_IDX_W-1:0]      idx;
  logic [`TAG_W-1:0]          wr_tag;
  logic [`TAG_W-1:0]          wr_ppn;
  logic [`TAG_W-1:0]          lookup_tag;
  logic                       hit;
  logic [`TAG_W-1:0]          rd_ppn;
  modport owner (output wr_en, inv_all, idx, wr_tag, wr_ppn, lookup_tag, input hit, rd_ppn);
  modport mem   (input wr_en, inv_all, idx, wr_tag, wr_ppn, lookup_tag, output hit, rd_ppn);
endinterface : tlb_if
`default_nettype wire

// file: verilog/tlb_mem.sv
// tlb_mem.sv: direct-mapped look-aside memory of page entries, registered read data.
// assumes a synchronous active-high reset and one clock.
`timescale 1ns/1ns
`default_nettype none
`include "iommu_params.svh"
module tlb_mem (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  tlb_if.mem        port_if
);
  logic [`TLB_DEPTH-1:0] valid_q;
  logic [`TLB_DEPTH-1:0] valid_d;
  logic [`TAG_W-1:0]     tag_mem [`TLB_DEPTH];
  logic [`TAG_W-1:0]     ppn_mem [`TLB_DEPTH];
  logic                  hit_q;
  logic [`TAG_W-1:0]     ppn_q;

  always_comb begin
    valid_d = valid_q;
    if (port_if.wr_en) begin
      valid_d[port_if.idx] = 1'b1;
    end
    if (port_if.inv_all) begin
      valid_d = '0; // see [R11]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      valid_q <= '0;
      hit_q   <= 1'b0;
      ppn_q   <= `TAG_RST;
    end else begin
      valid_q <= valid_d;
      hit_q   <= valid_q[port_if.idx] && tag_mem[port_if.idx] == port_if.lookup_tag && !port_if.inv_all;
      ppn_q   <= ppn_mem[port_if.idx];
    end
  end

  // storage arrays carry no reset; the valid bits guard them
  always_ff @(posedge ref_clk) begin
    if (port_if.wr_en) begin
      tag_mem[port_if.idx] <= port_if.wr_tag;
      ppn_mem[port_if.idx] <= port_if.wr_ppn;
    end
  end

  assign port_if.hit    = hit_q;
  assign port_if.rd_ppn = ppn_q;
endmodule : tlb_mem
`default_nettype wire
